// file: rtl/fcd_copro.sv
// Function
// RULE_01: resume suspended operation after context restore
// RULE_02: host stays silent during context restore
// RULE_03: host writes command then reads response
// RULE_04: execution starts fourth clock of read
// RULE_05: memory source answers ea-transfer, come-again set
// RULE_06: host passes counter first, two clocks
// RULE_07: host transfers 32-bit single operand
// RULE_08: operand handoff three clocks after write
// RULE_09: conversion waits for operand handoff
// RULE_10: host come-again ten clocks, null four
// RULE_11: host ends with null primitive
//
// Purpose: coprocessor end of the dialog
// Assumes: bus cycles last READ_CYCLE_CLKS clocks, req held throughout
// Notes: execution unit modelled as a conversion/compute counter
//        a save in the last conversion clock lets the work finish
`timescale 1ns/1ps
module fcd_copro (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    fcd_if.copro bus,
    input wire logic exc_enable_i,
    input wire logic save_i,
    output logic busy_o,
    output logic converting_o,
    output logic [31:0] operand_o,
    output logic done_o
);
    typedef enum logic [2:0] {
        FCD_IDLE = 3'h0,
        FCD_CMD = 3'h1,
        FCD_WAIT_OP = 3'h3,
        FCD_HANDOFF = 3'h2,
        FCD_CONVERT = 3'h6,
        FCD_SUSPEND = 3'h7
    } fcd_state_t;

    fcd_state_t state;
    fcd_state_t next_state;
    logic [2:0] bus_cnt;
    logic [3:0] work_cnt;
    logic mem_src;
    logic bus_end;
    logic [fcd_pkg::PRIM_W-1:0] next_prim;
    logic [fcd_pkg::PRIM_W-1:0] prim;
    logic wr_end;
    logic exec_start;
    logic hand_last;
    logic conv_last;

    // a write to the wanted register ends in this clock
    function automatic logic wr_done(input logic fin, input logic [1:0] s,
            input logic [1:0] want);
        wr_done = fin && (s == want);
    endfunction

    // bus cycle counter; cycle ends at last clock with ack
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bus_cnt <= 3'h0;
        end else if (clk_en_i) begin
            if (!bus.req || bus_end) begin
                bus_cnt <= 3'h0;
            end else begin
                bus_cnt <= bus_cnt + 3'h1;
            end
        end
    end
    assign bus_end = bus.req &&
        (bus_cnt == 3'(fcd_pkg::READ_CYCLE_CLKS - 1));
    assign bus.ack = bus_end;
    // a write cycle ends in this clock
    assign wr_end = bus_end && bus.wr;

    // RULE_04: execution starts fourth read clock
    assign exec_start = bus.req && !bus.wr &&
        bus.sel == fcd_pkg::REG_RESPONSE &&
        bus_cnt == 3'(fcd_pkg::EXEC_START_CLK - 1);
    // last clock of operand handoff and of conversion
    assign hand_last = work_cnt == 4'(fcd_pkg::HANDOFF_CLKS - 1);
    assign conv_last = work_cnt == 4'(fcd_pkg::CONVERT_CLKS - 1);

    // response primitive selection
    always_comb begin
        next_prim = '0;
        if (state == FCD_CMD && mem_src) begin
            // RULE_05: ea transfer answer
            next_prim[3:0] = fcd_pkg::PRIM_EA_XFER;
            next_prim[fcd_pkg::COME_AGAIN_BIT] = 1'b1;
            next_prim[fcd_pkg::PASS_COUNTER_BIT] = exc_enable_i;
        end else begin
            next_prim[3:0] = fcd_pkg::PRIM_NULL;
        end
    end

    // read data register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prim <= '0;
        end else if (clk_en_i && bus.req && !bus.wr && bus_cnt == 3'h0) begin
            prim <= next_prim;
        end
    end
    assign bus.rdata = {16'h0000, prim};

    // dialog state machine
    always_comb begin
        next_state = state;
        case (state)
            FCD_IDLE: begin
                if (wr_done(wr_end, bus.sel, fcd_pkg::REG_COMMAND)) begin
                    next_state = FCD_CMD;
                end
            end
            FCD_CMD: begin
                // RULE_04: start in fourth read clock
                if (exec_start) begin
                    next_state = mem_src ? FCD_WAIT_OP : FCD_CONVERT;
                end
            end
            FCD_WAIT_OP: begin
                if (wr_done(wr_end, bus.sel, fcd_pkg::REG_OPERAND)) begin
                    next_state = FCD_HANDOFF;
                end
            end
            FCD_HANDOFF: begin
                // RULE_08: three clock handoff
                if (hand_last) begin
                    next_state = FCD_CONVERT;
                end
            end
            FCD_CONVERT: begin
                // the last clock wins over a save, so a resumed counter
                // never starts beyond its end point and wraps
                if (conv_last) begin
                    next_state = FCD_IDLE;
                end else if (save_i) begin
                    next_state = FCD_SUSPEND;
                end
            end
            FCD_SUSPEND: begin
                // RULE_01: resume without new command
                if (wr_done(wr_end, bus.sel, fcd_pkg::REG_RESTORE)) begin
                    next_state = FCD_CONVERT;
                end
            end
            default: begin
                next_state = FCD_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= FCD_IDLE;
        end else if (clk_en_i) begin
            state <= next_state;
        end
    end

    // work counter; held across suspension so conversion resumes
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            work_cnt <= 4'h0;
        end else if (clk_en_i) begin
            if (state != next_state && next_state != FCD_SUSPEND &&
                state != FCD_SUSPEND) begin
                work_cnt <= 4'h0;
            end else if (state == FCD_HANDOFF || state == FCD_CONVERT) begin
                work_cnt <= work_cnt + 4'h1;
            end
        end
    end

    // command latch: source kind of the instruction just written
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_src <= 1'b0;
        end else if (clk_en_i && state == FCD_IDLE &&
            wr_done(wr_end, bus.sel, fcd_pkg::REG_COMMAND)) begin
            mem_src <= bus.wdata[fcd_pkg::CMD_MEM_BIT];
        end
    end

    // operand capture at the end of the operand write
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            operand_o <= '0;
        end else if (clk_en_i && state == FCD_WAIT_OP &&
            wr_done(wr_end, bus.sel, fcd_pkg::REG_OPERAND)) begin
            operand_o <= bus.wdata;
        end
    end

    // done pulse at end of conversion
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            done_o <= 1'b0;
        end else if (clk_en_i) begin
            done_o <= (state == FCD_CONVERT) && (next_state == FCD_IDLE);
        end
    end

    // busy while an instruction is open or suspended
    assign busy_o = (state != FCD_IDLE);
    // RULE_09: memory-source ops convert only after handoff
    assign converting_o = (state == FCD_CONVERT);
endmodule

// file: rtl/fcd_pkg.sv
// Purpose: shared constants for the coprocessor dialog link
// Assumes: both ends share sys_clk_i
// Notes: primitive codes and timing counts in one place
package fcd_pkg;
    // interface register selectors
    localparam logic [1:0] REG_COMMAND = 2'h0;
    localparam logic [1:0] REG_RESPONSE = 2'h1;
    localparam logic [1:0] REG_OPERAND = 2'h2;
    localparam logic [1:0] REG_RESTORE = 2'h3;
    // response primitive layout
    localparam int PRIM_W = 16;
    localparam int COME_AGAIN_BIT = 15;
    localparam int PASS_COUNTER_BIT = 14;
    localparam logic [3:0] PRIM_NULL = 4'h0;
    localparam logic [3:0] PRIM_EA_XFER = 4'h1;
    localparam logic [3:0] PRIM_BUSY = 4'h2;
    // command word fields
    localparam int CMD_MEM_BIT = 14;
    // timing counts in clocks, then operand width in bits
    localparam int READ_CYCLE_CLKS = 4;
    localparam int EXEC_START_CLK = 4;
    localparam int PASS_COUNTER_CLKS = 2;
    localparam int HANDOFF_CLKS = 3;
    localparam int COME_AGAIN_CLKS = 10;
    localparam int NULL_CLKS = 4;
    localparam int CONVERT_CLKS = 8;
    localparam int OPERAND_W = 32;
endpackage

// file: rtl/fcd_if.sv
// Purpose: host/coprocessor dialog wires
// Assumes: one common clock
// Notes: host owns request side, coprocessor owns answer side
`timescale 1ns/1ps
interface fcd_if;
    logic req;
    logic wr;
    logic [1:0] sel;
    logic [31:0] wdata;
    logic ack;
    logic [31:0] rdata;
    modport host (output req, output wr, output sel, output wdata,
                  input ack, input rdata);
    modport copro (input req, input wr, input sel, input wdata,
                   output ack, output rdata);
endinterface

// file: rtl/fcd_host.sv
// Purpose: host end of the dialog
// Assumes: coprocessor acks each 4-clock bus cycle
// Notes: one general instruction per start pulse
`timescale 1ns/1ps
module fcd_host (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    fcd_if.host bus,
    input wire logic start_i,
    input wire logic [15:0] cmd_i,
    input wire logic [31:0] operand_i,
    input wire logic restore_i,
    output logic ready_o,
    output logic counter_passed_o
);
    typedef enum logic [2:0] {
        FCDH_IDLE = 3'h0,
        FCDH_CMD = 3'h1,
        FCDH_RESP = 3'h3,
        FCDH_PASS = 3'h2,
        FCDH_OPND = 3'h6,
        FCDH_AGAIN = 3'h7,
        FCDH_NULL = 3'h5,
        FCDH_RST = 3'h4
    } fcdh_state_t;

    fcdh_state_t state;
    fcdh_state_t next_state;
    logic [3:0] cnt;
    logic [15:0] resp;
    logic cnt_done;

    function automatic logic at_count(input logic [3:0] c, input int n);
        at_count = (c == 4'(n - 1));
    endfunction

    always_comb begin
        next_state = state;
        cnt_done = 1'b0;
        case (state)
            FCDH_IDLE: begin
                if (restore_i) begin
                    next_state = FCDH_RST;
                end else if (start_i) begin
                    next_state = FCDH_CMD;
                end
            end
            // RULE_03: command then response read
            FCDH_CMD: if (bus.ack) next_state = FCDH_RESP;
            FCDH_RESP: begin
                if (bus.ack) begin
                    if (!resp[fcd_pkg::COME_AGAIN_BIT]) begin
                        next_state = FCDH_NULL;
                    end else if (resp[fcd_pkg::PASS_COUNTER_BIT]) begin
                        next_state = FCDH_PASS;
                    end else begin
                        next_state = FCDH_OPND;
                    end
                end
            end
            FCDH_PASS: begin
                // RULE_06: two clock counter pass
                cnt_done = at_count(cnt, fcd_pkg::PASS_COUNTER_CLKS);
                if (cnt_done) next_state = FCDH_OPND;
            end
            // RULE_07: 32-bit operand write
            FCDH_OPND: if (bus.ack) next_state = FCDH_AGAIN;
            FCDH_AGAIN: begin
                // RULE_10: come-again ten clocks
                cnt_done = at_count(cnt, fcd_pkg::COME_AGAIN_CLKS);
                if (cnt_done) next_state = FCDH_NULL;
            end
            FCDH_NULL: begin
                // RULE_11: null primitive ends instruction
                cnt_done = at_count(cnt, fcd_pkg::NULL_CLKS);
                if (cnt_done) next_state = FCDH_IDLE;
            end
            // RULE_02: restore, no dialog reopened
            FCDH_RST: if (bus.ack) next_state = FCDH_IDLE;
            default: next_state = FCDH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= FCDH_IDLE;
            cnt <= 4'h0;
        end else if (clk_en_i) begin
            state <= next_state;
            cnt <= (state != next_state) ? 4'h0 : cnt + 4'h1;
        end
    end

    // pass counter indicator
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            counter_passed_o <= 1'b0;
        end else if (clk_en_i) begin
            counter_passed_o <= (state == FCDH_PASS) && cnt_done;
        end
    end

    // bus request drive
    always_comb begin
        bus.req = 1'b1;
        bus.wr = 1'b1;
        bus.sel = fcd_pkg::REG_COMMAND;
        bus.wdata = {16'h0000, cmd_i};
        case (state)
            FCDH_CMD: bus.sel = fcd_pkg::REG_COMMAND;
            FCDH_RESP: begin
                bus.wr = 1'b0;
                bus.sel = fcd_pkg::REG_RESPONSE;
            end
            FCDH_OPND: begin
                bus.sel = fcd_pkg::REG_OPERAND;
                bus.wdata = operand_i;
            end
            FCDH_RST: bus.sel = fcd_pkg::REG_RESTORE;
            default: bus.req = 1'b0;
        endcase
    end
    assign resp = bus.rdata[15:0];
    assign ready_o = (state == FCDH_IDLE);
endmodule

// file: sim/fcd_checker.sv
// Purpose: protocol checks on the host/coprocessor dialog wires
// Assumes: one clock, asynchronous active-low reset
// Notes: sees only the interface signals
`timescale 1ns/1ps
module fcd_checker (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic req,
    input wire logic wr,
    input wire logic [1:0] sel,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // decoded answer points of the dialog
    logic resp_ack;
    logic op_ack;
    logic ea_prim;
    assign resp_ack = ack && !wr && sel == fcd_pkg::REG_RESPONSE;
    assign op_ack = ack && wr && sel == fcd_pkg::REG_OPERAND;
    assign ea_prim = resp_ack && rdata[3:0] == fcd_pkg::PRIM_EA_XFER;
    ack_late_a: assert property (ack |-> req && $past(req)
        && $past(req, 2) && $past(req, 3)) else $error("early ack");
    ack_single_a: assert property (ack |=> !ack [*3])
        else $error("ack too soon after ack");
    req_hold_a: assert property (req && !ack |=> req && $stable(sel)
        && $stable(wr) && $stable(wdata)) else $error("request changed");
    cmd_resp_a: assert property (ack && wr
        && sel == fcd_pkg::REG_COMMAND |=> req && !wr
        && sel == fcd_pkg::REG_RESPONSE) else $error("no response read");
    ea_again_a: assert property (ea_prim
        |-> rdata[fcd_pkg::COME_AGAIN_BIT])
        else $error("transfer primitive without come-again");
    null_again_a: assert property (resp_ack
        && rdata[3:0] == fcd_pkg::PRIM_NULL
        |-> !rdata[fcd_pkg::COME_AGAIN_BIT])
        else $error("null primitive with come-again");
    counter_pass_a: assert property (ea_prim
        && rdata[fcd_pkg::PASS_COUNTER_BIT]
        |=> !req [*2] ##1 (req && wr && sel == fcd_pkg::REG_OPERAND))
        else $error("counter pass not two clocks");
    no_pass_a: assert property (ea_prim
        && !rdata[fcd_pkg::PASS_COUNTER_BIT]
        |=> req && wr && sel == fcd_pkg::REG_OPERAND)
        else $error("operand write not next");
    come_again_a: assert property (op_ack |=> !req [*8])
        else $error("bus reopened during come-again");
    restore_quiet_a: assert property (ack && wr
        && sel == fcd_pkg::REG_RESTORE |=> !req [*4])
        else $error("dialog reopened after restore");
endmodule

// file: sim/testbench.sv
// Purpose: host and coprocessor ends driven against each other
// Assumes: clock enables tied high
// Notes: expected operands queued by the driver, popped on done
`timescale 1ns/1ps
module testbench;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic start_i = 1'b0;
    logic restore_i = 1'b0;
    logic exc_enable_i = 1'b0;
    logic save_i = 1'b0;
    logic [15:0] cmd_i = 16'h0000;
    logic [31:0] operand_i = 32'h00000000;
    logic ready_o, counter_passed_o, busy_o, converting_o, done_o;
    logic [31:0] operand_o;
    logic [32:0] note;
    logic [32:0] exp_q[$];
    integer seed = 32'h86ca;
    int n_fail = 0;
    int num_checks = 0;
    int gap = -1;
    int pass_seen = 0;
    int pass_exp = 0;
    logic cur_mem = 1'b0;
    logic resp_seen = 1'b0;
    int done_cnt = 0;
    int held;
    fcd_if bus_if();
    fcd_host i_fcd_host (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .clk_en_i(1'b1), .bus(bus_if), .start_i(start_i), .cmd_i(cmd_i),
        .operand_i(operand_i), .restore_i(restore_i), .ready_o(ready_o),
        .counter_passed_o(counter_passed_o));
    fcd_copro i_fcd_copro (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .clk_en_i(1'b1), .bus(bus_if), .exc_enable_i(exc_enable_i),
        .save_i(save_i), .busy_o(busy_o), .converting_o(converting_o),
        .operand_o(operand_o), .done_o(done_o));
    fcd_checker i_fcd_checker (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .req(bus_if.req), .wr(bus_if.wr), .sel(bus_if.sel),
        .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata));
    always #10 sys_clk_i = ~sys_clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // waits for both ends to go quiet, bounded
    task automatic wait_idle();
        int k;
        k = 0;
        while (!(ready_o === 1'b1 && busy_o === 1'b0) && k < 500) begin
            @(negedge sys_clk_i);
            k++;
        end
        if (k >= 500) begin
            n_fail++;
            final_report();
        end
    endtask
    // one general op: start pulse and its expected operand note
    task automatic run_op(input logic mem, input logic exc, input logic [31:0] v);
        @(negedge sys_clk_i);
        cmd_i = {v[15], mem, v[13:0]};
        exc_enable_i = exc;
        operand_i = v;
        start_i = 1'b1;
        exp_q.push_back({mem, v});
        cur_mem = mem;
        if (mem && exc) pass_exp++;
        @(negedge sys_clk_i);
        start_i = 1'b0;
        @(negedge sys_clk_i);
    endtask
    // compares each finished memory op with the oldest note
    always @(posedge sys_clk_i) begin
        if (counter_passed_o === 1'b1) pass_seen++;
        if (done_o === 1'b1) begin
            done_cnt++;
            note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h0;
            if (note[32]) check(operand_o, note[31:0]);
        end
    end
    always @(posedge sys_clk_i) begin
        if ((bus_if.ack & bus_if.wr) === 1'b1
            && bus_if.sel === fcd_pkg::REG_OPERAND) gap = 0;
        else if (gap >= 0 && converting_o === 1'b1) begin
            check(32'(gap), 32'(fcd_pkg::HANDOFF_CLKS));
            gap = -1;
        end else if (gap >= 0) gap++;
    end
    // register ops run right after the response read, memory ops wait
    always @(posedge sys_clk_i) begin
        if (resp_seen) check(32'(converting_o), 32'(!cur_mem));
        resp_seen = (bus_if.ack & ~bus_if.wr) === 1'b1
            && bus_if.sel === fcd_pkg::REG_RESPONSE;
    end
    initial begin
        repeat (12) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        for (int i = 0; i < 8; i++) begin
            run_op(i[0], i[1], $random(seed));
            wait_idle();
            $display("test %0d done", i);
        end
        run_op(1'b1, 1'b0, $random(seed));
        for (int k = 0; k < 60 && converting_o !== 1'b1; k++) @(negedge sys_clk_i);
        save_i = 1'b1;
        held = done_cnt;
        repeat (20) @(negedge sys_clk_i);
        check(32'(done_cnt), 32'(held));
        check(32'(busy_o), 32'h1);
        check(32'(converting_o), 32'h0);
        save_i = 1'b0;
        restore_i = 1'b1;
        @(negedge sys_clk_i);
        restore_i = 1'b0;
        @(negedge sys_clk_i);
        wait_idle();
        repeat (4) @(negedge sys_clk_i);
        check(32'(done_cnt), 32'(held + 1));
        check(32'(ready_o), 32'h1);
        $display("test restore done");
        check(32'(exp_q.size()), 32'h0);
        check(32'(pass_seen), 32'(pass_exp));
        final_report();
    end
    // watchdog well beyond the expected run length
    initial begin
        #400000;
        n_fail++;
        final_report();
    end
endmodule
